/* logic/event_reg.sv */
`timescale 1ns/100ps
module event_reg
  import status_pkg::*;
#(
  parameter logic [15:0] EV_RESET = 16'h0000
) (
  input wire logic   sys_clk,
  input wire logic   rst_n,
  event_reg_if.owner bus
);

  typedef struct packed {
    logic [15:0] ev;
    logic [15:0] en;
  } state_t;

  state_t s_q;
  state_t s_d;

  always_comb begin
    s_d = s_q;
    if (bus.clear) begin
      s_d.ev = '0;
    end
    // set beats a clear in the same cycle
    s_d.ev = (s_d.ev | bus.events) & bus.mask;
    if (bus.wr_en) begin
      s_d.en = bus.wr_data & bus.mask;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q.ev <= EV_RESET;
      s_q.en <= EVT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.ev_q    = s_q.ev;
  assign bus.en_q    = s_q.en;
  assign bus.summary = |(s_q.ev & s_q.en);

endmodule

/* logic/event_reg_if.sv */
`timescale 1ns/100ps
interface event_reg_if;
  logic [15:0] events;
  logic [15:0] mask;
  logic        clear;
  logic        wr_en;
  logic [15:0] wr_data;
  logic [15:0] ev_q;
  logic [15:0] en_q;
  logic        summary;

  modport owner (input events, mask, clear, wr_en, wr_data, output ev_q, en_q, summary);
  modport user  (output events, mask, clear, wr_en, wr_data, input ev_q, en_q, summary);
endinterface

/* logic/instrument_status_summary.sv */
`timescale 1ns/100ps
// Behaviour
// - mask each summary bit with enable
// - or masked bits into request bit
// - enable mask clears at reset, zero write
// - enable mask written and read back
// - operation complete sets bit 0
// - request control bit 1 never set
// - empty-queue read sets bit 2
// - device fault sets bit 3
// - execution error sets bit 4
// - command errors set bit 5
// - power restore sets bit 7
// - operation register uses only bit 13
// - bit 13 from enabled instrument bit 1
// - instrument register uses only bit 1
// - calibration sets summary bit 0
// - measurement sets summary bit 4
// - trigger wait sets summary bit 5
// - arm wait sets summary bit 6
// - filter settled/off sets bit 8
// - running list sets bit 9
// - idle sets bit 10
// - events latch, reading clears them
// - summary when event and enable set
module instrument_status_summary
  import status_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic        cmd_enable,
  input  wire logic [2:0]  cmd_sel,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        clear_all,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  input  wire logic        op_complete,
  input  wire logic        query_empty,
  input  wire logic        device_fault,
  input  wire logic        exec_error,
  input  wire logic        syntax_error,
  input  wire logic        semantic_error,
  input  wire logic        get_error,
  input  wire logic        calibrating,
  input  wire logic        measuring,
  input  wire logic        trigger_wait,
  input  wire logic        arm_wait,
  input  wire logic        filter_settled,
  input  wire logic        filter_off,
  input  wire logic        list_running,
  input  wire logic        idle_state,
  input  wire logic        meas_summary,
  input  wire logic        error_avail,
  input  wire logic        quest_summary,
  input  wire logic        msg_avail,
  output logic [7:0]       status_byte,
  output logic             service_request
);

  typedef struct packed {
    logic [7:0]  service_request_enable;
    logic [7:0]  stb;
    logic        rqs;
    logic        rsp_v;
    logic [15:0] rsp;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [6:0]  cond1;
    logic [6:0]  cond2;
  } state_t;

  state_t s_q;
  state_t s_d;

  event_reg_if se_if ();
  event_reg_if op_if ();
  event_reg_if in_if ();
  event_reg_if os_if ();

  logic rd_cmd;
  logic wr_cmd;

  // qualifiers go in as arguments so the assigns see every change
  assign rd_cmd = cmd_valid && !cmd_write && !cmd_enable;
  assign wr_cmd = cmd_valid && cmd_write && cmd_enable;

  // read of a given event register clears it
  function automatic logic read_hit(input logic go, input logic [2:0] sel, input reg_sel_t want);
    read_hit = go && (sel == want);
  endfunction

  function automatic logic wr_hit(input logic go, input logic [2:0] sel, input reg_sel_t want);
    wr_hit = go && (sel == want);
  endfunction

  logic [7:0]  se_events;
  logic [15:0] oss_events;
  logic [6:0]  cond;
  logic [7:0]  stb_raw;

  // pins from the instrument core are asynchronous here
  assign cond = s_q.cond2;

  always_comb begin
    se_events = '0;
    se_events[SE_OPC_BIT]   = s_q.sync2[0];
    se_events[SE_REQCTL_BIT] = 1'b0;
    se_events[SE_QUERY_BIT] = s_q.sync2[1];
    se_events[SE_DEV_BIT]   = s_q.sync2[2];
    se_events[SE_EXEC_BIT]  = s_q.sync2[3];
    se_events[SE_CMD_BIT]   = |s_q.sync2[6:4];
    // power-on flag comes from reset value
    se_events[SE_PON_BIT]   = 1'b0;
  end

  always_comb begin
    oss_events = '0;
    oss_events[OSS_CAL_BIT]  = cond[0];
    oss_events[OSS_MEAS_BIT] = cond[1];
    oss_events[OSS_TRIG_BIT] = cond[2];
    oss_events[OSS_ARM_BIT]  = cond[3];
    oss_events[OSS_FILT_BIT] = cond[4];
    oss_events[OSS_LIST_BIT] = cond[5];
    oss_events[OSS_IDLE_BIT] = cond[6];
  end

  assign se_if.events  = {8'h00, se_events};
  assign se_if.mask    = {8'h00, SE_MASK};
  assign se_if.clear   = clear_all | read_hit(rd_cmd, cmd_sel, SEL_SE);
  assign se_if.wr_en   = wr_hit(wr_cmd, cmd_sel, SEL_SE);
  assign se_if.wr_data = cmd_wdata;

  // stale lower summary must not refill a level that clear_all empties
  // only bit 13 of the top register
  // bit 13 from enabled instrument summary
  assign op_if.events  = {2'b00, in_if.summary & !clear_all, 13'h0000};
  assign op_if.mask    = OPER_MASK;
  assign op_if.clear   = clear_all | read_hit(rd_cmd, cmd_sel, SEL_OPER);
  assign op_if.wr_en   = wr_hit(wr_cmd, cmd_sel, SEL_OPER);
  assign op_if.wr_data = cmd_wdata;

  // only bit 1 of the instrument register
  assign in_if.events  = {14'h0000, os_if.summary & !clear_all, 1'b0};
  assign in_if.mask    = INSTR_MASK;
  assign in_if.clear   = clear_all | read_hit(rd_cmd, cmd_sel, SEL_INSTR);
  assign in_if.wr_en   = wr_hit(wr_cmd, cmd_sel, SEL_INSTR);
  assign in_if.wr_data = cmd_wdata;

  assign os_if.events  = oss_events;
  assign os_if.mask    = OSS_MASK;
  assign os_if.clear   = clear_all | read_hit(rd_cmd, cmd_sel, SEL_OSS);
  assign os_if.wr_en   = wr_hit(wr_cmd, cmd_sel, SEL_OSS);
  assign os_if.wr_data = cmd_wdata;

  event_reg #(.EV_RESET({8'h00, SE_RESET})) u_std (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bus     (se_if)
  );

  event_reg #(.EV_RESET(EVT_RESET)) u_oper (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bus     (op_if)
  );

  event_reg #(.EV_RESET(EVT_RESET)) u_instr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bus     (in_if)
  );

  event_reg #(.EV_RESET(EVT_RESET)) u_oss (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bus     (os_if)
  );

  // summary bits do not latch; rebuilt each cycle
  always_comb begin
    stb_raw = '0;
    stb_raw[0] = s_q.sync2[7];
    stb_raw[2] = error_avail;
    stb_raw[3] = quest_summary;
    stb_raw[4] = msg_avail;
    stb_raw[5] = se_if.summary;
    stb_raw[SB_OSB_BIT] = op_if.summary;
  end

  always_comb begin
    s_d       = s_q;
    s_d.sync1 = {meas_summary, get_error, semantic_error, syntax_error,
                 exec_error, device_fault, query_empty, op_complete};
    s_d.sync2 = s_q.sync1;
    s_d.cond1 = {idle_state, list_running, filter_settled | filter_off,
                 arm_wait, trigger_wait, measuring, calibrating};
    s_d.cond2 = s_q.cond1;
    if (cmd_valid && cmd_write && cmd_sel == SEL_SRE) begin
      s_d.service_request_enable = cmd_wdata[7:0] & SRE_MASK;
    end
    s_d.rqs = |(stb_raw & s_q.service_request_enable & SRE_MASK);
    s_d.stb = stb_raw;
    s_d.stb[SB_RQS_BIT] = s_d.rqs;
    s_d.rsp_v = cmd_valid && !cmd_write;
    s_d.rsp   = '0;
    if (cmd_valid && !cmd_write) begin
      unique case (cmd_sel)
        SEL_SRE:   s_d.rsp = {8'h00, s_q.service_request_enable};
        SEL_SE:    s_d.rsp = cmd_enable ? se_if.en_q : se_if.ev_q;
        SEL_OPER:  s_d.rsp = cmd_enable ? op_if.en_q : op_if.ev_q;
        SEL_INSTR: s_d.rsp = cmd_enable ? in_if.en_q : in_if.ev_q;
        SEL_OSS:   s_d.rsp = cmd_enable ? os_if.en_q : os_if.ev_q;
        SEL_STB:   s_d.rsp = {8'h00, s_q.stb};
        // unmapped selects answer zero
        default:   s_d.rsp = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_valid       = s_q.rsp_v;
  assign rsp_data        = s_q.rsp;
  assign status_byte     = s_q.stb;
  assign service_request = s_q.rqs;

endmodule

/* logic/status_pkg.sv */
package status_pkg;

  // standard event bit positions
  localparam int unsigned SE_OPC_BIT    = 0;
  localparam int unsigned SE_REQCTL_BIT = 1;
  localparam int unsigned SE_QUERY_BIT  = 2;
  localparam int unsigned SE_DEV_BIT    = 3;
  localparam int unsigned SE_EXEC_BIT   = 4;
  localparam int unsigned SE_CMD_BIT    = 5;
  localparam int unsigned SE_USER_BIT   = 6;
  localparam int unsigned SE_PON_BIT    = 7;

  // status byte positions
  localparam int unsigned SB_SPARE_BIT = 1;
  localparam int unsigned SB_RQS_BIT   = 6;
  localparam int unsigned SB_OSB_BIT   = 7;

  // operation chain summary positions
  localparam int unsigned OPER_SUM_BIT  = 13;
  localparam int unsigned INSTR_SUM_BIT = 1;

  // operation state summary bit positions
  localparam int unsigned OSS_CAL_BIT   = 0;
  localparam int unsigned OSS_MEAS_BIT  = 4;
  localparam int unsigned OSS_TRIG_BIT  = 5;
  localparam int unsigned OSS_ARM_BIT   = 6;
  localparam int unsigned OSS_FILT_BIT  = 8;
  localparam int unsigned OSS_LIST_BIT  = 9;
  localparam int unsigned OSS_IDLE_BIT  = 10;

  // implemented-bit masks; others read zero, ignore writes
  localparam logic [7:0]  SRE_MASK   = 8'hbd;
  localparam logic [7:0]  SE_MASK    = 8'hbd;
  localparam logic [15:0] OPER_MASK  = 16'h2000;
  localparam logic [15:0] INSTR_MASK = 16'h0002;
  localparam logic [15:0] OSS_MASK   = 16'h0771;

  // reset values
  localparam logic [7:0]  SRE_RESET  = 8'h00;
  localparam logic [7:0]  SE_RESET   = 8'h80;
  localparam logic [15:0] EVT_RESET  = 16'h0000;

  // register selects on the command port
  typedef enum logic [2:0] {
    SEL_SRE   = 3'h0,
    SEL_SE    = 3'h1,
    SEL_OPER  = 3'h2,
    SEL_INSTR = 3'h3,
    SEL_OSS   = 3'h4,
    SEL_STB   = 3'h5
  } reg_sel_t;

  // transfer phase codes: idle, read, done
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RD   = 2'b01,
    PH_DONE = 2'b11
  } phase_t;

endpackage

/* tb/controller_model.sv */
`timescale 1ns/100ps
module controller_model (
  input  wire logic        sys_clk,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic             cmd_enable,
  output logic [2:0]       cmd_sel,
  output logic [15:0]      cmd_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_enable = 1'b0;
    cmd_sel = 3'h0;
    cmd_wdata = 16'h0000;
  end

  task automatic xfer(input logic w, input logic en, input logic [2:0] sel, input logic [15:0] wd,
                      output logic [15:0] d, output logic v);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_enable = en;
    cmd_sel = sel;
    cmd_wdata = wd;
    @(negedge sys_clk);
    d = rsp_data;
    v = rsp_valid;
    // idle lines scrambled so stale data cannot pass
    cmd_valid = 1'b0;
    cmd_wdata = ~wd;
    cmd_enable = ~en;
  endtask
endmodule

/* tb/status_asserts.sv */
`timescale 1ns/100ps
module status_asserts (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [2:0]  cmd_sel,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [7:0]  status_byte,
  input wire logic        service_request
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic rd;
  assign rd = cmd_valid && !cmd_write;

  a_read_answered: assert property (rd |=> rsp_valid) else $error("read got no response");
  a_no_stray_rsp: assert property (!rd |=> !rsp_valid) else $error("response without read");
  a_idle_rsp_zero: assert property (!rsp_valid |-> rsp_data == 16'h0000) else $error("idle data nonzero");
  a_se_reqctl_low: assert property (rd && cmd_sel == 3'h1 |=> rsp_data[1] == 1'b0 && rsp_data[15:8] == 8'h00)
    else $error("standard event bad bits");
  a_oper_only13: assert property (rd && cmd_sel == 3'h2 |=> (rsp_data & 16'hdfff) == 16'h0000)
    else $error("operation unused bits set");
  a_instr_only1: assert property (rd && cmd_sel == 3'h3 |=> (rsp_data & 16'hfffd) == 16'h0000)
    else $error("instrument unused bits set");
  a_sre_unused: assert property (rd && cmd_sel == 3'h0 |=> (rsp_data & 16'hff42) == 16'h0000)
    else $error("enable mask unused bits");
  a_rqs_mirror: assert property (service_request == status_byte[6]) else $error("request pin differs");
  a_rqs_needs_bit: assert property (service_request |-> (status_byte & 8'hbd) != 8'h00)
    else $error("request without summary bit");
  a_spare_low: assert property (status_byte[1] == 1'b0) else $error("spare status bit set");

  c_read_std: cover property (rd && cmd_sel == 3'h1);
  c_write_sre: cover property (cmd_valid && cmd_write && cmd_sel == 3'h0);
  c_request: cover property ($rose(service_request));
endmodule

bind instrument_status_summary status_asserts chk_u (.sys_clk, .rst_n, .cmd_valid, .cmd_write, .cmd_sel,
  .rsp_valid, .rsp_data, .status_byte, .service_request);

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clear_all = 1'b0;
  logic        meas_summary = 1'b0;
  logic        error_avail = 1'b0;
  logic        quest_summary = 1'b0;
  logic        msg_avail = 1'b0;
  logic [6:0]  se_pins = 7'h00;
  logic [7:0]  st_pins = 8'h00;
  logic        cmd_valid, cmd_write, cmd_enable, rsp_valid, service_request;
  logic [2:0]  cmd_sel;
  logic [15:0] cmd_wdata, rsp_data;
  logic [7:0]  status_byte;
  integer      fails = 0;
  integer      checks_done = 0;
  localparam logic [15:0] SE_EXP [7] = '{16'h01, 16'h04, 16'h08, 16'h10, 16'h20, 16'h20, 16'h20};
  localparam logic [15:0] ST_EXP [8] = '{16'h01, 16'h10, 16'h20, 16'h40, 16'h100, 16'h100, 16'h200, 16'h400};

  always #5 sys_clk = ~sys_clk;

  controller_model ctl_u (.sys_clk, .cmd_valid, .cmd_write, .cmd_enable, .cmd_sel, .cmd_wdata, .rsp_valid,
    .rsp_data);
  instrument_status_summary dut_u (.sys_clk, .rst_n, .cmd_valid, .cmd_write, .cmd_enable, .cmd_sel, .cmd_wdata,
    .clear_all, .rsp_valid, .rsp_data, .op_complete(se_pins[0]), .query_empty(se_pins[1]),
    .device_fault(se_pins[2]), .exec_error(se_pins[3]), .syntax_error(se_pins[4]), .semantic_error(se_pins[5]),
    .get_error(se_pins[6]), .calibrating(st_pins[0]), .measuring(st_pins[1]), .trigger_wait(st_pins[2]),
    .arm_wait(st_pins[3]), .filter_settled(st_pins[4]), .filter_off(st_pins[5]), .list_running(st_pins[6]),
    .idle_state(st_pins[7]), .meas_summary, .error_avail, .quest_summary, .msg_avail, .status_byte,
    .service_request);

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input string what, input logic en, input logic [2:0] sel, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    ctl_u.xfer(1'b0, en, sel, 16'h0000, d, v);
    chk("rsp_valid", 16'h0001, {15'h0000, v});
    chk(what, exp, d);
  endtask

  task automatic wr(input logic en, input logic [2:0] sel, input logic [15:0] wd);
    logic [15:0] d;
    logic        v;
    ctl_u.xfer(1'b1, en, sel, wd, d, v);
  endtask

  // sync plus chain latency is about six cycles
  task automatic settle();
    repeat (10) @(negedge sys_clk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    conclude();
  end

  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    rdchk("power on", 1'b0, 3'h1, 16'h0080);
    rdchk("read clear", 1'b0, 3'h1, 16'h0000);
    rdchk("sre reset", 1'b0, 3'h0, 16'h0000);
    wr(1'b0, 3'h0, 16'hffff);
    rdchk("sre", 1'b0, 3'h0, 16'h00bd);
    wr(1'b0, 3'h0, 16'h0000);
    rdchk("sre zero", 1'b0, 3'h0, 16'h0000);
    rdchk("unmapped", 1'b0, 3'h7, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      se_pins = 7'h01 << i;
      repeat (3) @(negedge sys_clk);
      se_pins = 7'h00;
      settle();
      rdchk("std event", 1'b0, 3'h1, SE_EXP[i]);
    end
    for (int i = 0; i < 8; i++) begin
      st_pins = 8'h01 << i;
      repeat (3) @(negedge sys_clk);
      st_pins = 8'h00;
      settle();
      rdchk("state event", 1'b0, 3'h4, ST_EXP[i]);
      rdchk("state cleared", 1'b0, 3'h4, 16'h0000);
    end
    $display("test events done");
    wr(1'b1, 3'h4, 16'h0010);
    wr(1'b1, 3'h3, 16'hffff);
    wr(1'b1, 3'h2, 16'h2000);
    wr(1'b0, 3'h0, 16'h0080);
    rdchk("state enable", 1'b1, 3'h4, 16'h0010);
    rdchk("instr enable", 1'b1, 3'h3, 16'h0002);
    st_pins[1] = 1'b1;
    settle();
    chk("request", 16'h0001, {15'h0000, service_request});
    rdchk("oper top", 1'b0, 3'h2, 16'h2000);
    rdchk("instr", 1'b0, 3'h3, 16'h0002);
    wr(1'b0, 3'h0, 16'h0000);
    wr(1'b1, 3'h1, 16'h0001);
    se_pins[0] = 1'b1;
    msg_avail = 1'b1;
    settle();
    chk("masked byte", 16'h00b0, {8'h00, status_byte & 8'hf0});
    rdchk("byte read", 1'b0, 3'h5, 16'h00b0);
    wr(1'b0, 3'h0, 16'h0010);
    settle();
    chk("request", 16'h0001, {15'h0000, service_request});
    se_pins[0] = 1'b0;
    st_pins[1] = 1'b0;
    msg_avail = 1'b0;
    settle();
    clear_all = 1'b1;
    @(negedge sys_clk);
    clear_all = 1'b0;
    settle();
    chk("cleared byte", 16'h0000, {8'h00, status_byte});
    rdchk("cleared std", 1'b0, 3'h1, 16'h0000);
    $display("test chain done");
    wr(1'b0, 3'h0, 16'h0008);
    meas_summary = 1'b1;
    error_avail = 1'b1;
    quest_summary = 1'b1;
    settle();
    chk("summary byte", 16'h004d, {8'h00, status_byte});
    wr(1'b0, 3'h0, 16'h0002);
    settle();
    chk("masked request", 16'h0000, {15'h0000, service_request});
    wr(1'b0, 3'h0, 16'h0004);
    meas_summary = 1'b0;
    error_avail = 1'b0;
    quest_summary = 1'b0;
    $display("test summary done");
    rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    rdchk("sre after restart", 1'b0, 3'h0, 16'h0000);
    rdchk("power on again", 1'b0, 3'h1, 16'h0080);
    chk("restart byte", 16'h0000, {8'h00, status_byte});
    $display("test restart done");
    conclude();
  end
endmodule
